// [rtl/freq_meter_irq_regs.svh]
// Register offsets, field positions, reset values and codes of the block.
`ifndef FREQ_METER_IRQ_REGS_SVH
`define FREQ_METER_IRQ_REGS_SVH

// Byte offsets of the registers on the peripheral bus.
`define OFFSET_IRQ_ENABLE 10'h010
`define OFFSET_IRQ_DISABLE 10'h014
`define OFFSET_IRQ_MASK 10'h018
`define OFFSET_IRQ_PENDING 10'h01C
`define OFFSET_IRQ_CLEAR 10'h020
`define OFFSET_MODULE_VERSION 10'h3FC

// Bus address width in bits and the number of interrupt sources.
`define ADDR_WIDTH 10
`define IRQ_COUNT 2

// Bit positions of the two events in every interrupt register.
`define BIT_MEASURE_DONE 0
`define BIT_REFERENCE_CLOCK_READY 1

// Reset values.
`define RESET_IRQ_MASK 2'h0
`define RESET_IRQ_PENDING 2'h0
`define RESET_STATUS_PREVIOUS 2'h0

// Field layout of the version register.
`define VERSION_NUMBER_LSB 0
`define VERSION_NUMBER_WIDTH 12
`define VERSION_VARIANT_LSB 16
`define VERSION_VARIANT_WIDTH 4

// Values of the version register; both are arbitrary.
`define VERSION_NUMBER_VALUE 12'h0A5
`define VERSION_VARIANT_VALUE 4'h0

`endif

// [rtl/freq_meter_irq_pkg.sv]
// Types shared by the interrupt register logic of the frequency meter.
package freq_meter_irq_pkg;

  typedef logic [1:0] irq_vec_type;

  typedef logic [31:0] word_type;

  // Listed in the order of the bus response encoding.
  typedef enum logic [1:0] {
    resp_okay,
    resp_exokay,
    resp_slverr,
    resp_decerr
  } axi_resp_type;

endpackage : freq_meter_irq_pkg

// [rtl/irq_ctrl_if.sv]
// Strobes and state passed between the register front end and its banks.
`timescale 1ns/1ps
interface irq_ctrl_if;
  import freq_meter_irq_pkg::*;

  irq_vec_type enable_write;
  irq_vec_type disable_write;
  irq_vec_type clear_write;
  irq_vec_type mask;
  irq_vec_type pending;

  modport front (
    output enable_write,
    output disable_write,
    output clear_write,
    input mask,
    input pending
  );

  modport bank (
    input enable_write,
    input disable_write,
    input clear_write,
    output mask,
    output pending
  );

endinterface : irq_ctrl_if

// [rtl/irq_mask_bank.sv]
// Interrupt mask bits, set by enable writes and cleared by disable writes.
`timescale 1ns/1ps
`include "freq_meter_irq_regs.svh"
module irq_mask_bank
  import freq_meter_irq_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Strobes in, mask out.
  irq_ctrl_if.bank ctrl
);

  irq_vec_type mask;
  irq_vec_type next_mask;

  always_comb begin
    // Zero bits in either strobe leave the mask alone.
    next_mask = (mask | ctrl.enable_write) & ~ctrl.disable_write;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= `RESET_IRQ_MASK;
    end else begin
      mask <= next_mask;
    end
  end

  assign ctrl.mask = mask;

endmodule : irq_mask_bank

// [rtl/irq_pending_bank.sv]
// Pending bits set on falling edges of the internal status bits.
`timescale 1ns/1ps
`include "freq_meter_irq_regs.svh"
module irq_pending_bank
  import freq_meter_irq_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Internal status bits watched for a one to zero change.
  input wire irq_vec_type status,
  // Clear strobes in, pending bits out.
  irq_ctrl_if.bank ctrl
);

  irq_vec_type status_previous;
  irq_vec_type pending;
  irq_vec_type next_pending;
  irq_vec_type falling;

  genvar i;
  generate
    for (i = 0; i < `IRQ_COUNT; i++) begin : g_bit
      // A new event wins over a clear in the same cycle.
      assign falling[i] = status_previous[i] & ~status[i];
      assign next_pending[i] = falling[i] |
        (pending[i] & ~ctrl.clear_write[i]);
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_previous <= `RESET_STATUS_PREVIOUS;
      pending <= `RESET_IRQ_PENDING;
    end else begin
      status_previous <= status;
      pending <= next_pending;
    end
  end

  assign ctrl.pending = pending;

endmodule : irq_pending_bank

// [rtl/freq_meter_irq_regs.sv]
// AXI4-Lite register front end and interrupt output of the frequency meter.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "freq_meter_irq_regs.svh"
module freq_meter_irq_regs
  import freq_meter_irq_pkg::*;
#(
  // Fields of the version register; the default values are arbitrary.
  parameter logic [`VERSION_NUMBER_WIDTH-1:0] VERSION_NUMBER =
    `VERSION_NUMBER_VALUE,
  parameter logic [`VERSION_VARIANT_WIDTH-1:0] VERSION_VARIANT =
    `VERSION_VARIANT_VALUE
)
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel.
  input wire logic [`ADDR_WIDTH-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // Write data channel.
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response channel.
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address channel.
  input wire logic [`ADDR_WIDTH-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // Read data channel.
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Internal status: bit 0 measurement busy, bit 1 reference clock not ready.
  input wire irq_vec_type status,
  // Interrupt request to the system interrupt controller.
  output logic irq
);

  // The front end drives the write strobes of the interface; the two banks
  // own the mask and pending bits and hand them back for reads and for the
  // request output.
  irq_ctrl_if ctrl ();

  // Write side state.
  logic aw_held;
  logic next_aw_held;
  logic w_held;
  logic next_w_held;
  logic [`ADDR_WIDTH-1:0] aw_addr;
  logic [`ADDR_WIDTH-1:0] next_aw_addr;
  word_type w_data;
  word_type next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;

  // The write response waiting for the master.
  logic b_valid;
  logic next_b_valid;
  axi_resp_type b_resp;
  axi_resp_type next_b_resp;

  // Strobe and decode results of the write cycle.
  logic write_go;
  logic write_mapped;
  logic low_lane;

  // Read side state.
  logic r_valid;
  logic next_r_valid;
  word_type r_data;
  word_type next_r_data;
  axi_resp_type r_resp;
  axi_resp_type next_r_resp;

  // Decode results of the offered read address.
  word_type read_word;
  logic read_mapped;

  // Per-source request: pending and enabled together.
  irq_vec_type irq_active;

  // The address and data channels are taken independently, in any order.
  // Each is parked in a holding register until its partner arrives. The
  // register write is applied in the cycle after the later handshake, and
  // the response is raised at the same edge that updates the register.
  // Neither channel is accepted again until the response has been taken,
  // so at most one write is ever in flight.
  assign awready = !aw_held && !b_valid;
  assign wready = !w_held && !b_valid;
  // The write is applied once both halves are held and no answer waits.
  assign write_go = aw_held && w_held && !b_valid;
  // Lane zero carries the event bits.
  assign low_lane = w_strb[0];

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_b_valid = b_valid;
    next_b_resp = b_resp;
    // Park the address until its data arrives.
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    // Park the data and strobes until the address arrives.
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    // Apply the write and raise the response in the same step.
    if (write_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_b_valid = 1'b1;
      next_b_resp = write_mapped ? resp_okay : resp_slverr;
    end else if (b_valid && bready) begin
      next_b_valid = 1'b0;
    end
  end

  // Holding registers and the pending write response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= 4'h0;
      b_valid <= 1'b0;
      b_resp <= resp_okay;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      b_valid <= next_b_valid;
      b_resp <= next_b_resp;
    end
  end

  // Only the lowest byte lane carries event bits; upper bits are dropped.
  // A write with that lane switched off is answered but changes nothing.
  // The strobes are single-cycle pulses, high only in the write cycle.
  always_comb begin
    ctrl.enable_write = '0;
    ctrl.disable_write = '0;
    ctrl.clear_write = '0;
    write_mapped = 1'b1;
    // Decode on the held address; the low two bits are ignored.
    unique case ({aw_addr[`ADDR_WIDTH-1:2], 2'b00})
      `OFFSET_IRQ_ENABLE: begin
        if (write_go && low_lane) begin
          ctrl.enable_write = w_data[1:0];
        end
      end
      `OFFSET_IRQ_DISABLE: begin
        if (write_go && low_lane) begin
          ctrl.disable_write = w_data[1:0];
        end
      end
      `OFFSET_IRQ_CLEAR: begin
        if (write_go && low_lane) begin
          ctrl.clear_write = w_data[1:0];
        end
      end
      // Writes to read-only registers are accepted and ignored.
      `OFFSET_IRQ_MASK, `OFFSET_IRQ_PENDING, `OFFSET_MODULE_VERSION: begin
        write_mapped = 1'b1;
      end
      default: begin
        // Outside the map: slave error and no effect.
        write_mapped = 1'b0;
      end
    endcase
  end

  // Response outputs come straight from their flip-flops.
  assign bvalid = b_valid;
  assign bresp = b_resp;

  // Read decode; write-only registers read as zero.
  // The word is formed from the address as it is offered, so the data
  // captured with the handshake shows the bank state of that cycle.
  always_comb begin
    read_word = '0;
    read_mapped = 1'b1;
    // Decode on the offered address; the low two bits are ignored.
    unique case ({araddr[`ADDR_WIDTH-1:2], 2'b00})
      `OFFSET_IRQ_MASK: begin
        read_word[1:0] = ctrl.mask;
      end
      `OFFSET_IRQ_PENDING: begin
        read_word[1:0] = ctrl.pending;
      end
      `OFFSET_MODULE_VERSION: begin
        // The variant is reported but has no function.
        read_word[`VERSION_NUMBER_LSB +: `VERSION_NUMBER_WIDTH] =
          VERSION_NUMBER;
        read_word[`VERSION_VARIANT_LSB +: `VERSION_VARIANT_WIDTH] =
          VERSION_VARIANT;
      end
      `OFFSET_IRQ_ENABLE, `OFFSET_IRQ_DISABLE, `OFFSET_IRQ_CLEAR: begin
        read_word = '0;
      end
      default: begin
        // Outside the map: slave error, data zero.
        read_mapped = 1'b0;
      end
    endcase
  end

  // A new read is refused while the previous answer still waits.
  assign arready = !r_valid;

  // Reads have no side effect on any register.
  // The answer is raised at the edge after the handshake and held, with its
  // data and code, until the master takes it.
  always_comb begin
    next_r_valid = r_valid;
    next_r_data = r_data;
    next_r_resp = r_resp;
    // Capture the word and code with the handshake.
    if (arvalid && arready) begin
      next_r_valid = 1'b1;
      next_r_data = read_word;
      next_r_resp = read_mapped ? resp_okay : resp_slverr;
    end else if (r_valid && rready) begin
      next_r_valid = 1'b0;
    end
  end

  // Read answer registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_valid <= 1'b0;
      r_data <= '0;
      r_resp <= resp_okay;
    end else begin
      r_valid <= next_r_valid;
      r_data <= next_r_data;
      r_resp <= next_r_resp;
    end
  end

  // Answer outputs come straight from their flip-flops.
  assign rvalid = r_valid;
  assign rdata = r_data;
  assign rresp = r_resp;

  // Enable and disable strobes are merged into the mask bits.
  irq_mask_bank u_mask (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctrl(ctrl.bank)
  );

  // Falling edges of the status bits set the pending bits.
  irq_pending_bank u_pending (
    .aclk(aclk),
    .aresetn(aresetn),
    .status(status),
    .ctrl(ctrl.bank)
  );

  // One request term per source.
  genvar k;
  generate
    for (k = 0; k < `IRQ_COUNT; k++) begin : g_irq
      assign irq_active[k] = ctrl.pending[k] & ctrl.mask[k];
    end
  endgenerate

  // Both operands are flip-flops, so the request drops with the clear.
  assign irq = |irq_active;

endmodule : freq_meter_irq_regs

// [verification/freq_meter_irq_monitor.sv]
// Checker of the interrupt register block, watching its ports.
`timescale 1ns/1ps
module freq_meter_irq_monitor
  import freq_meter_irq_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus.
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [9:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Events and request.
  input wire irq_vec_type status,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic mapped;
  assign mapped = araddr[9:2] inside {8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
    8'hFF};
  sequence s_write_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_read_taken;
    arvalid && arready;
  endsequence
  a_irq_after_reset: assert property (
    !$past(aresetn) |-> !irq) else $error("irq high after reset");
  a_irq_rise_cause: assert property (
    $rose(irq) |-> $rose(bvalid) || |($past(status, 2) & ~$past(status)))
    else $error("irq rose without cause");
  a_irq_fall_cause: assert property (
    $fell(irq) |-> $rose(bvalid) || !$past(aresetn))
    else $error("irq fell without cause");
  a_write_answer: assert property (
    s_write_taken |-> ##[1:2] bvalid) else $error("no write response");
  a_read_answer: assert property (
    s_read_taken |=> rvalid) else $error("no read response");
  a_read_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data not held");
  a_write_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  a_read_code: assert property (
    s_read_taken |=> rresp == ($past(mapped) ? 2'h0 : 2'h2))
    else $error("wrong read response code");
  a_upper_zero: assert property (
    (s_read_taken and (araddr != 10'h3FC)) |=> rdata[31:2] == '0)
    else $error("reserved bits not zero");
  a_version_spare: assert property (
    (s_read_taken and (araddr == 10'h3FC)) |=> rdata[31:20] == '0)
    else $error("version upper bits not zero");
endmodule : freq_meter_irq_monitor

bind freq_meter_irq_regs freq_meter_irq_monitor mon (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp,
  .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
  .rvalid, .rready, .status, .irq
);

// [verification/irq_sink_model.sv]
// Interrupt controller model that counts rising requests.
`timescale 1ns/1ps
module irq_sink_model (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Request line and count.
  input wire logic irq,
  output logic [7:0] irq_count
);
  logic irq_seen;
  always_ff @(posedge aclk) begin
    irq_seen <= aresetn && irq;
    if (!aresetn) begin
      irq_count <= 8'h00;
    end else if (irq && !irq_seen) begin
      irq_count <= irq_count + 8'h01;
    end
  end
endmodule : irq_sink_model

// [verification/freq_meter_irq_regs_tb_top.sv]
// Self-checking bench of the interrupt register block.
`timescale 1ns/1ps
module freq_meter_irq_regs_tb_top;
  import freq_meter_irq_pkg::*;
  typedef struct {
    logic wr;
    logic [9:0] a;
    logic [31:0] d;
    logic [1:0] r;
  } row_type;
  logic aclk = 0;
  logic aresetn = 0;
  logic [9:0] awaddr = 0;
  logic [9:0] araddr = 0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic bready = 0;
  logic arvalid = 0;
  logic rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 4'hF;
  irq_vec_type status = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, q;
  logic [7:0] irq_count;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  row_type rows [10] = '{
    '{1'b0, 10'h018, 32'h0000_0000, 2'h0},
    '{1'b0, 10'h01C, 32'h0000_0000, 2'h0},
    '{1'b0, 10'h3FC, 32'h0009_03C7, 2'h0},
    '{1'b1, 10'h010, 32'hFFFF_FFFF, 2'h0},
    '{1'b0, 10'h018, 32'h0000_0003, 2'h0},
    '{1'b1, 10'h014, 32'h0000_0002, 2'h0},
    '{1'b1, 10'h014, 32'hFFFF_FFFC, 2'h0},
    '{1'b1, 10'h018, 32'h0000_0000, 2'h0},
    '{1'b0, 10'h018, 32'h0000_0001, 2'h0},
    '{1'b0, 10'h100, 32'h0000_0000, 2'h2}
  };
  freq_meter_irq_regs #(.VERSION_NUMBER(12'h3C7), .VERSION_VARIANT(4'h9))
    DUT (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .status, .irq);
  irq_sink_model host (.aclk, .aresetn, .irq, .irq_count);
  initial begin
    forever #50 aclk = ~aclk;
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One bus access; the master holds each channel until it is taken.
  task automatic xfer(input logic wr, input logic [9:0] a,
    input logic [31:0] d);
    int n;
    logic done;
    n = 0;
    done = 0;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    while (!done && n < 40) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (arvalid && arready) arvalid <= 0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 0;
        done = 1;
      end
      if (rvalid && rready) begin
        r = rresp;
        q = rdata;
        rready <= 0;
        done = 1;
      end
    end
    if (!done) n_fail++;
  endtask : xfer
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask : rd
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
  endtask : do_reset
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    do_reset();
    foreach (rows[i]) begin
      xfer(rows[i].wr, rows[i].a, rows[i].d);
      chk({30'h0, r}, {30'h0, rows[i].r});
      if (!rows[i].wr && rows[i].r == 2'h0) chk(q, rows[i].d);
    end
    status <= 2'b10;
    repeat (2) @(posedge aclk);
    status <= 2'b00;
    rd(10'h01C, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0000);
    status <= 2'b01;
    rd(10'h01C, 32'h0000_0002);
    status <= 2'b00;
    rd(10'h01C, 32'h0000_0003);
    chk({31'h0, irq}, 32'h0000_0001);
    chk({24'h0, irq_count}, 32'h0000_0001);
    xfer(1'b1, 10'h020, 32'hFFFF_FFFC);
    rd(10'h01C, 32'h0000_0003);
    xfer(1'b1, 10'h020, 32'h0000_0001);
    rd(10'h01C, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0000);
    xfer(1'b1, 10'h010, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0001);
    xfer(1'b1, 10'h020, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(10'h01C, 32'h0000_0000);
    // A write with byte lane zero off is answered and changes nothing.
    wstrb <= 4'hE;
    xfer(1'b1, 10'h014, 32'h0000_0003);
    chk({30'h0, r}, 32'h0000_0000);
    rd(10'h018, 32'h0000_0003);
    wstrb <= 4'hF;
    // A status fall in the cycle of its clear leaves the bit pending.
    status <= 2'b01;
    fork
      xfer(1'b1, 10'h020, 32'h0000_0001);
      begin
        repeat (2) @(posedge aclk);
        status <= 2'b00;
      end
    join
    rd(10'h01C, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    chk({24'h0, irq_count}, 32'h0000_0003);
    xfer(1'b1, 10'h020, 32'h0000_0001);
    rd(10'h01C, 32'h0000_0000);
    do_reset();
    rd(10'h018, 32'h0000_0000);
    print_verdict();
  end
endmodule : freq_meter_irq_regs_tb_top
